/* File: hdl/cqf_consts.svh */
// Constants for the coprocessor command buffer pointer block
// Assumes inclusion by bare name from the package and the design modules
`ifndef CQF_CONSTS_SVH
`define CQF_CONSTS_SVH

`define CQF_ADDR_W          12
`define CQF_DATA_W          32
`define CQF_PTR_W           12
`define CQF_DL_W            13
`define CQF_WORD_IDX_W      10
`define CQF_BUF_WORDS       1024
`define CQF_OFF_CMD_READ    12'h0f8
`define CQF_OFF_CMD_WRITE   12'h0fc
`define CQF_OFF_DL_OFFSET   12'h100
`define CQF_OFF_FREE_SPACE  12'h574
`define CQF_OFF_BULK_PORT   12'h578
`define CQF_OFF_CMD_RAM     12'h580
`define CQF_OFF_INT_STATUS  12'h590
`define CQF_OFF_INT_ENABLE  12'h594
`define CQF_OFF_INT_CLEAR   12'h598
`define CQF_OFF_ERR_CODE    12'h59c
`define CQF_RST_PTR         12'h000
`define CQF_RST_DL          13'h0000
`define CQF_RST_FREE        12'hffc
`define CQF_ERR_PTR         12'hfff
`define CQF_RESERVE         12'h004
`define CQF_CMD_STEP        12'h004
`define CQF_DL_STEP         13'h0004
`define CQF_INT_W           3
`define CQF_INT_FETCH       0
`define CQF_INT_ERROR       1
`define CQF_INT_EMPTY       2
`define CQF_ERR_OPCODE      8'hff
`define CQF_DL_OPCODE       8'h01

`endif

/* File: hdl/cqf_pkg.sv */
// Types shared by the command buffer pointer block
// Assumes the constants header is on the include path
`include "cqf_consts.svh"
package cqf_pkg;
  typedef struct packed {
    logic                   wr;
    logic                   rd;
    logic [`CQF_ADDR_W-1:0] addr;
    logic [`CQF_DATA_W-1:0] wdata;
  } cqf_bus_req_t;

  typedef struct packed {
    logic                   valid;
    logic [`CQF_DL_W-1:0]   addr;
    logic [`CQF_DATA_W-1:0] data;
  } cqf_dl_wr_t;

  typedef enum logic [3:0] {
    CQF_IDLE  = 4'b0001,
    CQF_FETCH = 4'b0010,
    CQF_EXEC  = 4'b0100,
    CQF_HALT  = 4'b1000
  } cqf_state_t;
endpackage

/* File: hdl/cqf_cmd_ram.sv */
// Command buffer memory of 1024 words, one write and one registered read port
// Assumes word indices from the pointer logic; one clock domain
`include "cqf_consts.svh"
module cqf_cmd_ram (
  // Clock
  input  wire logic                          clk_in,
  // Write port
  input  wire logic                          we_in,
  input  wire logic [`CQF_WORD_IDX_W-1:0]    waddr_in,
  input  wire logic [`CQF_DATA_W-1:0]        wdata_in,
  // Read port
  input  wire logic [`CQF_WORD_IDX_W-1:0]    raddr_in,
  output logic      [`CQF_DATA_W-1:0]        rdata_out
);
  logic [`CQF_DATA_W-1:0] mem [0:`CQF_BUF_WORDS-1];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_out <= mem[raddr_in];
  end
endmodule

/* File: hdl/cqf_irq.sv */
// Sticky interrupt status with enable and write-one-to-clear
// Assumes one-cycle event pulses and clear strobes in the clock domain
`include "cqf_consts.svh"
module cqf_irq (
  // Clock and reset
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  // Events and software control
  input  wire logic [`CQF_INT_W-1:0]   event_in,
  input  wire logic                    clear_we_in,
  input  wire logic [`CQF_INT_W-1:0]   clear_in,
  input  wire logic [`CQF_INT_W-1:0]   enable_in,
  // Results
  output logic      [`CQF_INT_W-1:0]   status_out,
  output logic                         irq_out
);
  logic [`CQF_INT_W-1:0] status_next;

  genvar i;
  generate
    for (i = 0; i < `CQF_INT_W; i = i + 1) begin : g_bit
      // Set wins over a clear in the same cycle
      assign status_next[i] = event_in[i] | (status_out[i] & ~(clear_we_in & clear_in[i]));
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      status_out <= '0;
    end else begin
      status_out <= status_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_next & enable_in);
    end
  end
endmodule

/* File: hdl/cqf_top.sv */
// Command buffer pointers, free space, bulk port and display-list offset
// Assumes a plain register port with read data one cycle later; one clock
//
// What this block does
// - A 13-bit offset into display list memory marks where the next generated command goes.
// - The engine writes its display-list output at that offset and advances it per display-list command.
// - The host writes a 12-bit write pointer that the engine uses as the producer index.
// - The buffer holds 4096 bytes and each instruction takes four bytes.
// - The engine advances a host-writable 12-bit read pointer as it fetches each command.
// - On an error the engine forces the read pointer to all ones.
// - The host writes the read pointer only to recover, and reset returns it to zero.
// - A read-only 12-bit free-space count resets to 0xffc.
// - Each word written to the bulk port lands at the write position and advances it.
`include "cqf_consts.svh"
module cqf_top (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  // Register port
  input  wire logic [`CQF_ADDR_W-1:0]     addr_in,
  input  wire logic [`CQF_DATA_W-1:0]     wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [`CQF_DATA_W-1:0]     rdata_out,
  // Coprocessor engine reset
  input  wire logic                       engine_reset_in,
  // Display list output
  output logic                            dl_we_out,
  output logic      [`CQF_DL_W-1:0]       dl_addr_out,
  output logic      [`CQF_DATA_W-1:0]     dl_data_out,
  // Interrupt
  output logic                            irq_out
);
  cqf_pkg::cqf_bus_req_t   req;
  cqf_pkg::cqf_state_t     state_reg;
  cqf_pkg::cqf_state_t     state_next;
  cqf_pkg::cqf_dl_wr_t     dl_reg;

  logic [`CQF_PTR_W-1:0]   rd_ptr_reg;
  logic [`CQF_PTR_W-1:0]   wr_ptr_reg;
  logic [`CQF_DL_W-1:0]    dl_off_reg;
  logic [`CQF_PTR_W-1:0]   free_reg;
  logic [`CQF_PTR_W-1:0]   free_next;
  logic [`CQF_PTR_W-1:0]   used;
  logic [`CQF_INT_W-1:0]   int_en_reg;
  logic [`CQF_INT_W-1:0]   int_status;
  logic [`CQF_INT_W-1:0]   int_event;
  logic [7:0]              err_code_reg;
  logic                    irq;
  logic                    eng_rst;
  logic                    hit_rd;
  logic                    hit_wr;
  logic                    hit_dl;
  logic                    hit_bulk;
  logic                    hit_ram;
  logic                    hit_en;
  logic                    hit_clr;
  logic                    ram_we;
  logic [`CQF_WORD_IDX_W-1:0] ram_waddr;
  logic [`CQF_DATA_W-1:0]  ram_rdata;
  logic                    pending;
  logic                    exec_dl;
  logic                    exec_err;
  logic                    fetch_done;

  assign req.wr    = wr_in;
  assign req.rd    = rd_in;
  assign req.addr  = addr_in;
  assign req.wdata = wdata_in;
  assign eng_rst   = !rst_n_in || engine_reset_in;

  // Address decode
  always_comb begin
    hit_rd   = 1'b0;
    hit_wr   = 1'b0;
    hit_dl   = 1'b0;
    hit_bulk = 1'b0;
    hit_ram  = 1'b0;
    hit_en   = 1'b0;
    hit_clr  = 1'b0;
    if (req.addr == `CQF_OFF_CMD_READ) begin
      hit_rd = 1'b1;
    end else if (req.addr == `CQF_OFF_CMD_WRITE) begin
      hit_wr = 1'b1;
    end else if (req.addr == `CQF_OFF_DL_OFFSET) begin
      hit_dl = 1'b1;
    end else if (req.addr == `CQF_OFF_BULK_PORT) begin
      hit_bulk = 1'b1;
    end else if (req.addr == `CQF_OFF_CMD_RAM) begin
      hit_ram = 1'b1;
    end else if (req.addr == `CQF_OFF_INT_ENABLE) begin
      hit_en = 1'b1;
    end else if (req.addr == `CQF_OFF_INT_CLEAR) begin
      hit_clr = 1'b1;
    end
  end

  // Direct RAM writes go at the write pointer without advancing it
  assign ram_we    = req.wr && (hit_bulk || hit_ram);
  assign ram_waddr = wr_ptr_reg[`CQF_PTR_W-1:2];

  cqf_cmd_ram u_ram (
    .clk_in    (clk_in),
    .we_in     (ram_we),
    .waddr_in  (ram_waddr),
    .wdata_in  (req.wdata),
    .raddr_in  (rd_ptr_reg[`CQF_PTR_W-1:2]),
    .rdata_out (ram_rdata)
  );

  // Commands waiting between read and write pointers
  assign pending = (rd_ptr_reg != wr_ptr_reg) && (rd_ptr_reg != `CQF_ERR_PTR);

  // Engine sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cqf_pkg::CQF_IDLE: begin
        if (pending) begin
          state_next = cqf_pkg::CQF_FETCH;
        end
      end
      cqf_pkg::CQF_FETCH: begin
        state_next = cqf_pkg::CQF_EXEC;
      end
      cqf_pkg::CQF_EXEC: begin
        if (exec_err) begin
          state_next = cqf_pkg::CQF_HALT;
        end else begin
          state_next = cqf_pkg::CQF_IDLE;
        end
      end
      cqf_pkg::CQF_HALT: begin
        if (rd_ptr_reg != `CQF_ERR_PTR) begin
          state_next = cqf_pkg::CQF_IDLE;
        end
      end
      default: begin
        state_next = cqf_pkg::CQF_IDLE;
      end
    endcase
  end

  assign exec_err   = (state_reg == cqf_pkg::CQF_EXEC) &&
                      (ram_rdata[31:24] == `CQF_ERR_OPCODE);
  assign exec_dl    = (state_reg == cqf_pkg::CQF_EXEC) &&
                      (ram_rdata[31:24] == `CQF_DL_OPCODE);
  assign fetch_done = (state_reg == cqf_pkg::CQF_EXEC) && !exec_err;

  always_ff @(posedge clk_in) begin
    if (eng_rst) begin
      state_reg <= cqf_pkg::CQF_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Read pointer
  always_ff @(posedge clk_in) begin
    if (eng_rst) begin
      rd_ptr_reg <= `CQF_RST_PTR;
    end else if (exec_err) begin
      rd_ptr_reg <= `CQF_ERR_PTR;
    end else if (req.wr && hit_rd) begin
      rd_ptr_reg <= req.wdata[`CQF_PTR_W-1:0];
    end else if (fetch_done) begin
      rd_ptr_reg <= rd_ptr_reg + `CQF_CMD_STEP;
    end
  end

  // Write pointer
  always_ff @(posedge clk_in) begin
    if (eng_rst) begin
      wr_ptr_reg <= `CQF_RST_PTR;
    end else if (req.wr && hit_wr) begin
      wr_ptr_reg <= req.wdata[`CQF_PTR_W-1:0];
    end else if (req.wr && hit_bulk) begin
      wr_ptr_reg <= wr_ptr_reg + `CQF_CMD_STEP;
    end
  end

  // Free space
  always_comb begin
    used = wr_ptr_reg - rd_ptr_reg;
    if (rd_ptr_reg == `CQF_ERR_PTR) begin
      free_next = `CQF_RST_PTR;
    end else begin
      free_next = `CQF_RST_FREE - used;
    end
  end

  always_ff @(posedge clk_in) begin
    if (eng_rst) begin
      free_reg <= `CQF_RST_FREE;
    end else begin
      free_reg <= free_next;
    end
  end

  // Display list offset and output
  always_ff @(posedge clk_in) begin
    if (eng_rst) begin
      dl_off_reg <= `CQF_RST_DL;
    end else if (req.wr && hit_dl) begin
      dl_off_reg <= req.wdata[`CQF_DL_W-1:0];
    end else if (exec_dl) begin
      dl_off_reg <= dl_off_reg + `CQF_DL_STEP;
    end
  end

  always_ff @(posedge clk_in) begin
    if (eng_rst) begin
      dl_reg <= '0;
    end else begin
      dl_reg.valid <= exec_dl;
      dl_reg.addr  <= dl_off_reg;
      dl_reg.data  <= {8'h00, ram_rdata[23:0]};
    end
  end

  assign dl_we_out   = dl_reg.valid;
  assign dl_addr_out = dl_reg.addr;
  assign dl_data_out = dl_reg.data;

  // Error code
  always_ff @(posedge clk_in) begin
    if (eng_rst) begin
      err_code_reg <= 8'h00;
    end else if (exec_err) begin
      err_code_reg <= ram_rdata[7:0];
    end
  end

  // Interrupts
  assign int_event[`CQF_INT_FETCH] = fetch_done;
  assign int_event[`CQF_INT_ERROR] = exec_err;
  assign int_event[`CQF_INT_EMPTY] = fetch_done && (rd_ptr_reg + `CQF_CMD_STEP == wr_ptr_reg);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      int_en_reg <= '0;
    end else if (req.wr && hit_en) begin
      int_en_reg <= req.wdata[`CQF_INT_W-1:0];
    end
  end

  cqf_irq u_irq (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .event_in    (int_event),
    .clear_we_in (req.wr && hit_clr),
    .clear_in    (req.wdata[`CQF_INT_W-1:0]),
    .enable_in   (int_en_reg),
    .status_out  (int_status),
    .irq_out     (irq)
  );

  assign irq_out = irq;

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (req.rd) begin
      if (req.addr == `CQF_OFF_CMD_READ) begin
        rdata_out <= {20'h00000, rd_ptr_reg};
      end else if (req.addr == `CQF_OFF_CMD_WRITE) begin
        rdata_out <= {20'h00000, wr_ptr_reg};
      end else if (req.addr == `CQF_OFF_DL_OFFSET) begin
        rdata_out <= {19'h00000, dl_off_reg};
      end else if (req.addr == `CQF_OFF_FREE_SPACE) begin
        rdata_out <= {20'h00000, free_reg};
      end else if (req.addr == `CQF_OFF_INT_STATUS) begin
        rdata_out <= {29'h00000000, int_status};
      end else if (req.addr == `CQF_OFF_INT_ENABLE) begin
        rdata_out <= {29'h00000000, int_en_reg};
      end else if (req.addr == `CQF_OFF_ERR_CODE) begin
        rdata_out <= {24'h000000, err_code_reg};
      end else begin
        rdata_out <= '0;
      end
    end else begin
      rdata_out <= '0;
    end
  end
endmodule

/* File: tb/cqf_top_monitor.sv */
// Checker for the command buffer pointer block
// Assumes it is bound to cqf_top and sees only its ports
`include "cqf_consts.svh"
module cqf_top_monitor (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // Register port
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  // Engine and outputs
  input wire logic        engine_reset_in,
  input wire logic        dl_we_out,
  input wire logic [12:0] dl_addr_out,
  input wire logic [31:0] dl_data_out,
  input wire logic        irq_out
);
  logic [12:0] dl_nxt_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Where the next display-list word should land
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || engine_reset_in) dl_nxt_reg <= 13'h0000;
    else if (wr_in && addr_in == `CQF_OFF_DL_OFFSET) dl_nxt_reg <= wdata_in[12:0];
    else if (dl_we_out) dl_nxt_reg <= dl_addr_out + 13'h0004;
  end
  rp_width_a: assert property (rd_in && addr_in == `CQF_OFF_CMD_READ |=>
    rdata_out[31:12] == 20'h0) else $error("read pointer too wide");
  wp_width_a: assert property (rd_in && addr_in == `CQF_OFF_CMD_WRITE |=>
    rdata_out[31:12] == 20'h0) else $error("write pointer too wide");
  dl_width_a: assert property (rd_in && addr_in == `CQF_OFF_DL_OFFSET |=>
    rdata_out[31:13] == 19'h0) else $error("offset too wide");
  space_word_a: assert property (rd_in && addr_in == `CQF_OFF_FREE_SPACE |=>
    rdata_out[31:12] == 20'h0 && rdata_out[1:0] == 2'h0) else $error("bad free space");
  bulk_read_a: assert property (rd_in && addr_in == `CQF_OFF_BULK_PORT |=>
    rdata_out == 32'h0) else $error("bulk port readable");
  dl_data_a: assert property (dl_we_out |-> dl_data_out[31:24] == 8'h00)
    else $error("display word top byte set");
  dl_step_a: assert property (dl_we_out |-> dl_addr_out == dl_nxt_reg)
    else $error("display offset not advanced");
  dl_pace_a: assert property (dl_we_out |=> !dl_we_out ##1 !dl_we_out)
    else $error("commands closer than three cycles");
  irq_fall_a: assert property ($fell(irq_out) |-> $past(wr_in) || $past(wr_in, 2))
    else $error("interrupt dropped without a write");
  eng_stop_a: assert property (engine_reset_in ##1 engine_reset_in |-> !dl_we_out)
    else $error("output while engine held");
  dl_c: cover property (dl_we_out);
  irq_c: cover property ($rose(irq_out));
  err_c: cover property (rd_in && addr_in == `CQF_OFF_CMD_READ ##1 rdata_out == 32'hfff);
  eng_c: cover property ($fell(engine_reset_in));
endmodule
bind cqf_top cqf_top_monitor mon (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .engine_reset_in(engine_reset_in),
  .dl_we_out(dl_we_out), .dl_addr_out(dl_addr_out), .dl_data_out(dl_data_out),
  .irq_out(irq_out)
);

/* File: tb/cqf_host_model.sv */
// Host side of the register port: single-cycle writes and reads
// Assumes the caller checks read data; strobes stay up between calls
`include "cqf_consts.svh"
module cqf_host_model (
  // Clock
  input  wire logic        clk_in,
  // Register port toward the device
  output logic      [11:0] addr_out,
  output logic      [31:0] wdata_out,
  output logic             wr_out,
  output logic             rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_out = 12'h000;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // Whole words only; write pointer and offset kept aligned and in range
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (a == `CQF_OFF_CMD_WRITE) v = d & 32'h0ffc;
    if (a == `CQF_OFF_DL_OFFSET) v = d & 32'h1ffc;
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    rd_out <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic get(input logic [11:0] a);
    addr_out <= a;
    rd_out <= 1'b1;
    wr_out <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic idle;
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    wdata_out <= ~wdata_out;
    @(posedge clk_in);
  endtask
endmodule

/* File: tb/cqf_top_test.sv */
// Self-checking bench for the command buffer pointer block
// Assumes the host model drives the register port; 50 MHz clock
`include "cqf_consts.svh"
module cqf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in;
  logic        rst_n_in;
  logic        engine_reset_in;
  logic [11:0] addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [31:0] rdata_out;
  logic        dl_we_out;
  logic [12:0] dl_addr_out;
  logic [31:0] dl_data_out;
  logic        irq_out;
  logic [44:0] rd_q[$];
  logic [44:0] dl_q[$];
  logic        rd_seen;
  int          error_cnt;
  int          tests_run;
  int          cyc;
  logic [11:0] a_tab [7] = '{12'h0f8, 12'h0fc, 12'h100, 12'h574, 12'h578, 12'h004, 12'h590};
  logic [31:0] e_tab [7] = '{32'h0, 32'h0, 32'h0, 32'hffc, 32'h0, 32'h0, 32'h0};

  cqf_top dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .engine_reset_in(engine_reset_in),
    .dl_we_out(dl_we_out), .dl_addr_out(dl_addr_out), .dl_data_out(dl_data_out),
    .irq_out(irq_out)
  );
  cqf_host_model host (
    .clk_in(clk_in), .addr_out(addr_in), .wdata_out(wdata_in), .wr_out(wr_in),
    .rd_out(rd_in)
  );

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back({13'h0, e});
    host.get(a);
  endtask
  task automatic wait_set(input int n);
    host.idle();
    repeat (n) @(posedge clk_in);
  endtask

  // Watcher: read answers and display-list words against the notes
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    rd_seen <= rd_in;
    if (rd_seen) chk(rdata_out, rd_q.pop_front());
    if (dl_we_out) chk({dl_addr_out, dl_data_out}, dl_q.pop_front());
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    rst_n_in = 1'b0;
    engine_reset_in = 1'b0;
    rd_seen = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(17));
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    foreach (a_tab[i]) rd(a_tab[i], e_tab[i]);
    // Offset at its top boundary, then one display-list command wraps it
    host.put(12'h100, 32'h1ffc);
    rd(12'h100, 32'h1ffc);
    dl_q.push_back({13'h1ffc, 32'h00abcdef});
    host.put(12'h578, 32'h01abcdef);
    wait_set(12);
    rd(12'h100, 32'h0);
    rd(12'h0f8, 32'h4);
    rd(12'h0fc, 32'h4);
    // Long random burst within the reported space, then a wrap
    rd(12'h574, 32'hffc);
    for (int n = 0; n < 1020; n++) host.put(12'h578, {8'h02, 24'($urandom)});
    wait_set(3200);
    rd(12'h0f8, 32'hff4);
    rd(12'h574, 32'hffc);
    for (int n = 0; n < 8; n++) host.put(12'h578, {8'h02, 24'($urandom)});
    wait_set(40);
    rd(12'h0f8, 32'h014);
    rd(12'h0fc, 32'h014);
    // Interrupts: masked events, clear, then an error raises the line
    host.put(12'h594, 32'h2);
    wait_set(3);
    chk(irq_out, 1'b0);
    rd(12'h590, 32'h5);
    host.put(12'h598, 32'h5);
    rd(12'h590, 32'h0);
    host.put(12'h578, 32'hff00005a);
    wait_set(12);
    chk(irq_out, 1'b1);
    rd(12'h0f8, 32'hfff);
    rd(12'h574, 32'h0);
    rd(12'h59c, 32'h5a);
    host.put(12'h598, 32'h2);
    wait_set(3);
    chk(irq_out, 1'b0);
    host.put(12'h0f8, 32'h018);
    wait_set(6);
    rd(12'h0f8, 32'h018);
    rd(12'h574, 32'hffc);
    // Engine reset, then deposit a word before advancing the pointer
    engine_reset_in <= 1'b1;
    wait_set(3);
    engine_reset_in <= 1'b0;
    foreach (a_tab[i]) if (i < 4) rd(a_tab[i], e_tab[i]);
    rd(12'h594, 32'h2);
    dl_q.push_back({13'h0, 32'h00000123});
    host.put(12'h580, 32'h01000123);
    host.put(12'h0fc, 32'h7);
    wait_set(12);
    rd(12'h0f8, 32'h4);
    rd(12'h100, 32'h4);
    wait_set(4);
    wrap_up();
  end
endmodule
